// File: uhp_pkg.sv
// Behaviour
// - bus-select high decodes separate read/write strobes; low decodes direction line.
// - reset pin is active high in strobe mode, active low in direction mode.
// - any reset pulse clears all registers and outputs but the oscillator output; the port holds reset 40 ns past pin release.
// - during reset transmit line is high, receive is ignored, outputs except the oscillator output stay reset.
// - isolate input high hides all host bus activity from the device.
// - each access carries 8 data bits and 3 address bits, eight locations.
// - bus cycles need no oscillator; bus logic is independent of the baud source.
// - bus cycles are asynchronous, framed by chip select with strobes or direction line.
// - transmit and receive data each sit in a separate 64-byte FIFO.
// - modem control bit 7 prescales the oscillator by 1 or 4.
// - with modem control bit 5 set, any received character other than XOFF resumes suspended transmit.
// - serial engine samples at four times the bit rate.
`default_nettype none
package uhp_pkg;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 3;
  localparam int          FIFO_DEPTH   = 64;
  localparam logic [2:0]  REG_DATA     = 3'h0;
  localparam logic [2:0]  REG_DIV      = 3'h1;
  localparam logic [2:0]  REG_XON      = 3'h2;
  localparam logic [2:0]  REG_XOFF     = 3'h3;
  localparam logic [2:0]  REG_MCR      = 3'h4;
  localparam logic [2:0]  REG_STAT     = 3'h5;
  localparam logic [2:0]  REG_LVL      = 3'h6;
  localparam logic [2:0]  REG_SCR      = 3'h7;
  localparam int          MCR_PRESCALE = 7;
  localparam int          MCR_ANYRES   = 5;
  localparam logic [7:0]  DIV_RST      = 8'h01;
  localparam logic [7:0]  MCR_RST      = 8'h00;
  localparam logic [7:0]  XON_RST      = 8'h11;
  localparam logic [7:0]  XOFF_RST     = 8'h13;
  localparam logic [1:0]  PRESCALE_TOP = 2'h3;
  localparam logic [1:0]  SAMPLE_LAST  = 2'h3;
  localparam logic [1:0]  SAMPLE_MID   = 2'h1;
  localparam logic [3:0]  FRAME_LAST   = 4'h9;
  localparam int          CLK_NS       = 10;
  localparam int          RST_MIN_NS   = 40;
  localparam logic [2:0]  RST_MIN_CYC  = 3'((RST_MIN_NS + CLK_NS - 1) / CLK_NS);

  typedef struct packed {
    logic              bus_sel;
    logic              reset_pin;
    logic              bus_isolate_in;
    logic              cs_n;
    logic              read_strobe_n;
    logic              write_strobe_n;
    logic              rw;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              rx;
    logic              osc_clock_in;
  } uhp_pins_type;

  typedef struct packed {
    logic              busy;
    logic [1:0]        phase;
    logic [3:0]        bitn;
    logic [9:0]        shift;
  } uhp_ser_type;
endpackage : uhp_pkg
`default_nettype wire

// File: uhp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module uhp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  localparam int AW   = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clr,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready,
  output logic [AW:0]           count
);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("uhp_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_r   [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign count     = cnt_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (clr) begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end else begin
      if (push) begin
        mem_nxt[wp_r] = in_data;
        wp_nxt        = wp_r + 1'b1;
      end
      if (pop) begin
        rp_nxt = rp_r + 1'b1;
      end
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule : uhp_fifo
`default_nettype wire

// File: uhp_host_port.sv
`timescale 1ns/1ns
`default_nettype none
module uhp_host_port (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire uhp_pkg::uhp_pins_type       pins,
  output logic [uhp_pkg::DATA_W-1:0]       data_out,
  output logic                             data_oe,
  output logic                             tx_out,
  output logic                             osc_clock_out,
  output logic                             tx_suspended
);
  localparam int CW = $clog2(uhp_pkg::FIFO_DEPTH) + 1;

  logic                  rs1_r, rs2_r;
  uhp_pkg::uhp_pins_type p1_r, p2_r, p3_r;

  logic [7:0]  div_r, div_nxt, mcr_r, mcr_nxt, xon_r, xon_nxt;
  logic [7:0]  xoff_r, xoff_nxt, scr_r, scr_nxt, dcnt_r, dcnt_nxt;
  logic [7:0]  dout_r, dout_nxt;
  logic [1:0]  pre_r, pre_nxt;
  logic [2:0]  hold_r, hold_nxt;
  logic [2:0]  raddr_r, raddr_nxt;
  logic        oe_r, oe_nxt, txo_r, txo_nxt, osc_r, osc_nxt;
  logic        susp_r, susp_nxt, ovr_r, ovr_nxt, ferr_r, ferr_nxt;
  uhp_pkg::uhp_ser_type tx_r, tx_nxt, rx_r, rx_nxt;

  logic        rst_act, srst, rd_act, rd_end, wr_evt, osc_rise, pre_tick, samp_tick;
  logic        txf_push, txf_ready, txf_valid, txf_pop;
  logic        rxf_push, rxf_ready, rxf_valid, rxf_pop;
  logic [7:0]  txf_data, txf_head, rxf_data, rx_byte;
  logic [CW-1:0] txf_cnt, rxf_cnt;

  // pin synchronisers, p3 is an extra stage for edge detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end

  always_ff @(posedge mclk or negedge rs2_r) begin
    if (!rs2_r) begin
      p1_r <= '0;
      p2_r <= '0;
      p3_r <= '0;
    end else begin
      p1_r <= pins;
      p2_r <= p1_r;
      p3_r <= p2_r;
    end
  end

  assign rst_act = p2_r.bus_sel ? p2_r.reset_pin : !p2_r.reset_pin;
  assign srst    = rst_act || (hold_r != 3'h0);

  // bus cycle decode, no dependence on the oscillator input
  always_comb begin
    if (p2_r.bus_sel) begin
      rd_act = !p2_r.cs_n && !p2_r.read_strobe_n;
      wr_evt = !p3_r.cs_n && !p3_r.write_strobe_n && p2_r.write_strobe_n;
    end else begin
      rd_act = !p2_r.cs_n && p2_r.rw;
      wr_evt = !p3_r.cs_n && !p3_r.rw && p2_r.cs_n;
    end
    if (p2_r.bus_isolate_in || srst) begin
      rd_act = 1'b0;
      wr_evt = 1'b0;
    end
  end

  assign rd_end    = oe_r && !rd_act;
  assign osc_rise  = p2_r.osc_clock_in && !p3_r.osc_clock_in;
  assign pre_tick  = osc_rise && (!mcr_r[uhp_pkg::MCR_PRESCALE] || pre_r == uhp_pkg::PRESCALE_TOP);
  assign samp_tick = pre_tick && ((dcnt_r + 8'h01) >= div_r);

  assign txf_push = wr_evt && (p3_r.addr == uhp_pkg::REG_DATA);
  assign txf_data = p3_r.data;
  assign rxf_pop  = rd_end && (raddr_r == uhp_pkg::REG_DATA);
  assign rx_byte  = rx_r.shift[7:0];

  always_comb begin
    div_nxt   = div_r;
    mcr_nxt   = mcr_r;
    xon_nxt   = xon_r;
    xoff_nxt  = xoff_r;
    scr_nxt   = scr_r;
    dcnt_nxt  = dcnt_r;
    pre_nxt   = pre_r;
    hold_nxt  = hold_r;
    raddr_nxt = raddr_r;
    susp_nxt  = susp_r;
    ovr_nxt   = ovr_r;
    ferr_nxt  = ferr_r;
    tx_nxt    = tx_r;
    rx_nxt    = rx_r;
    txf_pop   = 1'b0;
    rxf_push  = 1'b0;
    dout_nxt  = 8'h00;
    oe_nxt    = rd_act;
    osc_nxt   = p2_r.osc_clock_in;

    if (rd_act) begin
      raddr_nxt = p2_r.addr;
      case (p2_r.addr)
        uhp_pkg::REG_DATA: dout_nxt = rxf_data;
        uhp_pkg::REG_DIV:  dout_nxt = div_r;
        uhp_pkg::REG_XON:  dout_nxt = xon_r;
        uhp_pkg::REG_XOFF: dout_nxt = xoff_r;
        uhp_pkg::REG_MCR:  dout_nxt = mcr_r;
        uhp_pkg::REG_STAT: dout_nxt = {1'b0, ferr_r, ovr_r, susp_r, !rxf_ready,
                                       !txf_ready, !txf_valid, rxf_valid};
        uhp_pkg::REG_LVL:  dout_nxt = 8'(rxf_cnt);
        uhp_pkg::REG_SCR:  dout_nxt = scr_r;
        default:           dout_nxt = 8'h00;
      endcase
    end

    // sticky errors clear on status read end, a new event wins
    if (rd_end && raddr_r == uhp_pkg::REG_STAT) begin
      ovr_nxt  = 1'b0;
      ferr_nxt = 1'b0;
    end

    if (wr_evt) begin
      case (p3_r.addr)
        uhp_pkg::REG_DIV:  div_nxt  = p3_r.data;
        uhp_pkg::REG_XON:  xon_nxt  = p3_r.data;
        uhp_pkg::REG_XOFF: xoff_nxt = p3_r.data;
        uhp_pkg::REG_MCR:  mcr_nxt  = p3_r.data;
        uhp_pkg::REG_SCR:  scr_nxt  = p3_r.data;
        default:           scr_nxt  = scr_r;
      endcase
    end

    if (pre_tick) begin
      dcnt_nxt = samp_tick ? 8'h00 : dcnt_r + 8'h01;
    end
    if (osc_rise) begin
      pre_nxt = pre_r + 2'h1;
    end

    // transmitter, four sample ticks per bit
    if (samp_tick) begin
      if (!tx_r.busy) begin
        if (txf_valid && !susp_r) begin
          txf_pop  = 1'b1;
          tx_nxt   = '{busy: 1'b1, phase: 2'h0, bitn: 4'h0,
                       shift: {1'b1, txf_head, 1'b0}};
        end
      end else begin
        tx_nxt.phase = tx_r.phase + 2'h1;
        if (tx_r.phase == uhp_pkg::SAMPLE_LAST) begin
          tx_nxt.shift = {1'b1, tx_r.shift[9:1]};
          tx_nxt.bitn  = tx_r.bitn + 4'h1;
          if (tx_r.bitn == uhp_pkg::FRAME_LAST) begin
            tx_nxt.busy = 1'b0;
          end
        end
      end
    end

    // receiver samples mid-bit on the second tick
    if (samp_tick) begin
      if (!rx_r.busy) begin
        if (!p2_r.rx) begin
          rx_nxt = '{busy: 1'b1, phase: 2'h0, bitn: 4'h0, shift: 10'h000};
        end
      end else begin
        rx_nxt.phase = rx_r.phase + 2'h1;
        if (rx_r.phase == uhp_pkg::SAMPLE_MID) begin
          rx_nxt.bitn = rx_r.bitn + 4'h1;
          if (rx_r.bitn == 4'h0) begin
            rx_nxt.busy = !p2_r.rx;
          end else if (rx_r.bitn == uhp_pkg::FRAME_LAST) begin
            rx_nxt.busy = 1'b0;
            if (!p2_r.rx) begin
              ferr_nxt = 1'b1;
            end else begin
              rxf_push = 1'b1;
              if (!rxf_ready) begin
                ovr_nxt = 1'b1;
              end
              if (rx_byte == xoff_r) begin
                susp_nxt = 1'b1;
              end else if (rx_byte == xon_r || mcr_r[uhp_pkg::MCR_ANYRES]) begin
                susp_nxt = 1'b0;
              end
            end
          end else begin
            rx_nxt.shift = {2'b00, p2_r.rx, rx_r.shift[7:1]};
          end
        end
      end
    end

    txo_nxt = tx_r.busy ? tx_r.shift[0] : 1'b1;

    if (rst_act) begin
      hold_nxt = uhp_pkg::RST_MIN_CYC;
    end else if (hold_r != 3'h0) begin
      hold_nxt = hold_r - 3'h1;
    end
    if (srst) begin
      div_nxt   = uhp_pkg::DIV_RST;
      mcr_nxt   = uhp_pkg::MCR_RST;
      xon_nxt   = uhp_pkg::XON_RST;
      xoff_nxt  = uhp_pkg::XOFF_RST;
      scr_nxt   = 8'h00;
      dcnt_nxt  = 8'h00;
      pre_nxt   = 2'h0;
      raddr_nxt = 3'h0;
      susp_nxt  = 1'b0;
      ovr_nxt   = 1'b0;
      ferr_nxt  = 1'b0;
      tx_nxt    = '0;
      rx_nxt    = '0;
      txf_pop   = 1'b0;
      rxf_push  = 1'b0;
      dout_nxt  = 8'h00;
      oe_nxt    = 1'b0;
      txo_nxt   = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rs2_r) begin
    if (!rs2_r) begin
      div_r   <= uhp_pkg::DIV_RST;
      mcr_r   <= uhp_pkg::MCR_RST;
      xon_r   <= uhp_pkg::XON_RST;
      xoff_r  <= uhp_pkg::XOFF_RST;
      scr_r   <= 8'h00;
      dcnt_r  <= 8'h00;
      pre_r   <= 2'h0;
      hold_r  <= 3'h0;
      raddr_r <= 3'h0;
      susp_r  <= 1'b0;
      ovr_r   <= 1'b0;
      ferr_r  <= 1'b0;
      tx_r    <= '0;
      rx_r    <= '0;
      dout_r  <= 8'h00;
      oe_r    <= 1'b0;
      txo_r   <= 1'b1;
      osc_r   <= 1'b0;
    end else begin
      div_r   <= div_nxt;
      mcr_r   <= mcr_nxt;
      xon_r   <= xon_nxt;
      xoff_r  <= xoff_nxt;
      scr_r   <= scr_nxt;
      dcnt_r  <= dcnt_nxt;
      pre_r   <= pre_nxt;
      hold_r  <= hold_nxt;
      raddr_r <= raddr_nxt;
      susp_r  <= susp_nxt;
      ovr_r   <= ovr_nxt;
      ferr_r  <= ferr_nxt;
      tx_r    <= tx_nxt;
      rx_r    <= rx_nxt;
      dout_r  <= dout_nxt;
      oe_r    <= oe_nxt;
      txo_r   <= txo_nxt;
      osc_r   <= osc_nxt;
    end
  end

  uhp_fifo #(.WIDTH(uhp_pkg::DATA_W), .DEPTH(uhp_pkg::FIFO_DEPTH)) u_tx_fifo (
    .clk       (mclk),
    .rst_n     (rs2_r),
    .clr       (srst),
    .in_valid  (txf_push),
    .in_data   (txf_data),
    .in_ready  (txf_ready),
    .out_valid (txf_valid),
    .out_data  (txf_head),
    .out_ready (txf_pop),
    .count     (txf_cnt)
  );

  uhp_fifo #(.WIDTH(uhp_pkg::DATA_W), .DEPTH(uhp_pkg::FIFO_DEPTH)) u_rx_fifo (
    .clk       (mclk),
    .rst_n     (rs2_r),
    .clr       (srst),
    .in_valid  (rxf_push),
    .in_data   (rx_byte),
    .in_ready  (rxf_ready),
    .out_valid (rxf_valid),
    .out_data  (rxf_data),
    .out_ready (rxf_pop),
    .count     (rxf_cnt)
  );

  assign data_out      = dout_r;
  assign data_oe       = oe_r;
  assign tx_out        = txo_r;
  assign osc_clock_out = osc_r;
  assign tx_suspended  = susp_r;
endmodule : uhp_host_port
`default_nettype wire

// File: uhp_host_port_checker.sv
`timescale 1ns/1ns
`default_nettype none
module uhp_host_port_checker (
  input wire logic                        mclk,
  input wire logic                        rst_n,
  input wire uhp_pkg::uhp_pins_type       pins,
  input wire logic [uhp_pkg::DATA_W-1:0]  data_out,
  input wire logic                        data_oe,
  input wire logic                        tx_out,
  input wire logic                        osc_clock_out,
  input wire logic                        tx_suspended
);
  logic       pin_rst;
  logic       rd_cond;
  logic       live;
  logic [3:0] calm_r;
  logic [3:0] calm_nxt;
  assign pin_rst = pins.bus_sel ? pins.reset_pin : !pins.reset_pin;
  assign rd_cond = !pins.cs_n && (pins.bus_sel ? !pins.read_strobe_n : pins.rw);
  assign live    = (calm_r == 4'hF);
  // cycles since the reset pin was last active
  always_comb begin
    calm_nxt = pin_rst ? 4'h0 : (live ? calm_r : calm_r + 4'h1);
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) calm_r <= 4'h0;
    else calm_r <= calm_nxt;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_rst_tx; pin_rst [*4] |-> tx_out; endproperty
  a_rst_tx: assert property (p_rst_tx) else $error("tx not high in reset");
  property p_rst_bus; pin_rst [*4] |-> !data_oe && data_out == 8'h00; endproperty
  a_rst_bus: assert property (p_rst_bus) else $error("bus output not reset");
  property p_rst_susp; pin_rst [*4] |-> !tx_suspended; endproperty
  a_rst_susp: assert property (p_rst_susp) else $error("suspend not reset");
  property p_iso; pins.bus_isolate_in [*5] |-> !data_oe; endproperty
  a_iso: assert property (p_iso) else $error("bus driven while isolated");
  property p_strobe_rd;
    (live && pins.bus_sel && !pins.bus_isolate_in && rd_cond) [*4] |-> data_oe;
  endproperty
  a_strobe_rd: assert property (p_strobe_rd) else $error("strobe read not answered");
  property p_dir_rd;
    (live && !pins.bus_sel && !pins.bus_isolate_in && rd_cond) [*4] |-> data_oe;
  endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("direction read not answered");
  property p_idle; (!rd_cond) [*5] |-> !data_oe; endproperty
  a_idle: assert property (p_idle) else $error("bus driven without read");
  property p_osc; live |-> osc_clock_out == $past(pins.osc_clock_in, 3); endproperty
  a_osc: assert property (p_osc) else $error("osc output not following");
endmodule : uhp_host_port_checker
bind uhp_host_port uhp_host_port_checker chk_u (.mclk(mclk), .rst_n(rst_n), .pins(pins),
  .data_out(data_out), .data_oe(data_oe), .tx_out(tx_out), .osc_clock_out(osc_clock_out),
  .tx_suspended(tx_suspended));
`default_nettype wire

// File: uhp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module uhp_host_model (
  input  wire logic                        mclk,
  input  wire logic                        osc_run,
  input  wire logic [uhp_pkg::DATA_W-1:0]  data_out,
  input  wire logic                        data_oe,
  output var  uhp_pkg::uhp_pins_type       pins
);
  logic [1:0] osc_cnt = 2'h0;
  initial begin
    pins = '{bus_sel: 1'b1, cs_n: 1'b1, read_strobe_n: 1'b1, write_strobe_n: 1'b1,
             rw: 1'b1, rx: 1'b1, default: '0};
  end
  // oscillator stands still unless a serial test runs it
  always @(posedge mclk) begin
    if (osc_run) begin
      osc_cnt <= osc_cnt + 2'h1;
      if (osc_cnt == 2'h3) pins.osc_clock_in <= !pins.osc_clock_in;
    end
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    pins.addr <= a;
    pins.data <= d;
    pins.cs_n <= 1'b0;
    if (pins.bus_sel) pins.write_strobe_n <= 1'b0;
    else pins.rw <= 1'b0;
    repeat (4) @(posedge mclk);
    if (pins.bus_sel) pins.write_strobe_n <= 1'b1;
    else pins.cs_n <= 1'b1;
    @(posedge mclk);
    pins.cs_n <= 1'b1;
    pins.rw <= 1'b1;
    pins.data <= ~d;
    pins.addr <= ~a;
    repeat (4) @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic got);
    int n;
    @(posedge mclk);
    pins.addr <= a;
    pins.cs_n <= 1'b0;
    if (pins.bus_sel) pins.read_strobe_n <= 1'b0;
    else pins.rw <= 1'b1;
    got = 1'b0;
    for (n = 0; n < 20 && !got; n++) begin
      @(negedge mclk);
      got = (data_oe === 1'b1);
    end
    d = data_out;
    @(posedge mclk);
    pins.cs_n <= 1'b1;
    pins.read_strobe_n <= 1'b1;
    pins.addr <= ~a;
    repeat (4) @(posedge mclk);
  endtask : rd
  // serial frame on the receive pin: start bit, eight data bits low first, stop bit
  task automatic rx_send(input logic [7:0] b, input int bitc);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      pins.rx <= fr[i];
      repeat (bitc - 1) @(posedge mclk);
    end
  endtask : rx_send
endmodule : uhp_host_model
`default_nettype wire

// File: tb_uart_host_bus_port.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_uart_host_bus_port;
  localparam logic [2:0] RA [4] = '{uhp_pkg::REG_DIV, uhp_pkg::REG_XON,
                                    uhp_pkg::REG_XOFF, uhp_pkg::REG_MCR};
  localparam logic [7:0] RV [4] = '{uhp_pkg::DIV_RST, uhp_pkg::XON_RST,
                                    uhp_pkg::XOFF_RST, uhp_pkg::MCR_RST};
  logic                  mclk = 1'b0;
  logic                  rst_n;
  logic                  osc_run;
  logic                  got;
  logic                  tx_out;
  logic                  data_oe;
  logic                  osc_clock_out;
  logic                  tx_suspended;
  logic [7:0]            d;
  logic [7:0]            data_out;
  uhp_pkg::uhp_pins_type pins;
  int                    n_errors;
  int                    total_checks;
  int                    cycles = 0;
  uhp_host_port dut_u (.mclk(mclk), .rst_n(rst_n), .pins(pins), .data_out(data_out),
    .data_oe(data_oe), .tx_out(tx_out), .osc_clock_out(osc_clock_out),
    .tx_suspended(tx_suspended));
  uhp_host_model host_u (.mclk(mclk), .osc_run(osc_run), .data_out(data_out),
    .data_oe(data_oe), .pins(pins));
  always #5 mclk = ~mclk;
  task automatic finish_test;
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  // start bit, eight data bits low first, stop bit
  task automatic tx_check(input logic [7:0] b, input int bitc);
    int n;
    for (n = 0; n < 40 * bitc && tx_out !== 1'b0; n++) @(negedge mclk);
    repeat (bitc / 2) @(negedge mclk);
    `CHK(tx_out, 1'b0)
    for (n = 0; n < 8; n++) begin
      repeat (bitc) @(negedge mclk);
      `CHK(tx_out, b[n])
    end
    repeat (bitc) @(negedge mclk);
    `CHK(tx_out, 1'b1)
  endtask : tx_check
  initial begin
    rst_n = 1'b0;
    osc_run = 1'b0;
    n_errors = 0;
    total_checks = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (12) @(posedge mclk);
    `CHK(tx_out, 1'b1)
    `CHK(data_oe, 1'b0)
    `CHK(tx_suspended, 1'b0)
    for (int i = 0; i < 4; i++) begin
      host_u.rd(RA[i], d, got);
      `CHK(got, 1'b1)
      `CHK(d, RV[i])
    end
    host_u.wr(uhp_pkg::REG_SCR, 8'hA5);
    host_u.rd(uhp_pkg::REG_SCR, d, got);
    `CHK(d, 8'hA5)
    host_u.pins.bus_isolate_in <= 1'b1;
    repeat (4) @(posedge mclk);
    host_u.wr(uhp_pkg::REG_SCR, 8'h3C);
    host_u.rd(uhp_pkg::REG_SCR, d, got);
    `CHK(got, 1'b0)
    host_u.pins.bus_isolate_in <= 1'b0;
    repeat (4) @(posedge mclk);
    host_u.rd(uhp_pkg::REG_SCR, d, got);
    `CHK(d, 8'hA5)
    // one frame undivided, one with the divide by four prescaler
    for (int p = 0; p < 2; p++) begin
      host_u.wr(uhp_pkg::REG_MCR, p ? 8'h80 : 8'h00);
      osc_run <= 1'b1;
      d = p ? 8'hC3 : 8'h5A;
      host_u.wr(uhp_pkg::REG_DATA, d);
      tx_check(d, p ? 128 : 32);
      osc_run <= 1'b0;
      repeat (8) @(posedge mclk);
    end
    // receive path: XOFF holds transmit, XON or, with modem control bit 5 set, any other byte resumes
    host_u.wr(uhp_pkg::REG_MCR, 8'h00);
    osc_run <= 1'b1;
    host_u.rx_send(uhp_pkg::XOFF_RST, 32);
    `CHK(tx_suspended, 1'b1)
    host_u.wr(uhp_pkg::REG_DATA, 8'h96);
    repeat (20) @(posedge mclk);
    `CHK(tx_out, 1'b1)
    host_u.rx_send(8'h41, 32);
    `CHK(tx_suspended, 1'b1)
    host_u.rx_send(uhp_pkg::XON_RST, 32);
    `CHK(tx_suspended, 1'b0)
    tx_check(8'h96, 32);
    host_u.wr(uhp_pkg::REG_MCR, 8'h20);
    host_u.rx_send(uhp_pkg::XOFF_RST, 32);
    `CHK(tx_suspended, 1'b1)
    host_u.rx_send(8'h41, 32);
    `CHK(tx_suspended, 1'b0)
    osc_run <= 1'b0;
    host_u.rd(uhp_pkg::REG_LVL, d, got);
    `CHK(d, 8'h05)
    host_u.rd(uhp_pkg::REG_DATA, d, got);
    `CHK(d, uhp_pkg::XOFF_RST)
    host_u.rd(uhp_pkg::REG_DATA, d, got);
    `CHK(d, 8'h41)
    host_u.rd(uhp_pkg::REG_STAT, d, got);
    `CHK(d, 8'h03)
    host_u.wr(uhp_pkg::REG_DIV, 8'h07);
    // low reset pin becomes active once direction style is chosen
    host_u.pins.bus_sel <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK(tx_out, 1'b1)
    `CHK(data_oe, 1'b0)
    host_u.pins.reset_pin <= 1'b1;
    repeat (12) @(posedge mclk);
    host_u.rd(uhp_pkg::REG_DIV, d, got);
    `CHK(d, uhp_pkg::DIV_RST)
    host_u.wr(uhp_pkg::REG_DIV, 8'h07);
    host_u.rd(uhp_pkg::REG_DIV, d, got);
    `CHK(d, 8'h07)
    host_u.pins.reset_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    host_u.pins.reset_pin <= 1'b1;
    repeat (12) @(posedge mclk);
    host_u.rd(uhp_pkg::REG_DIV, d, got);
    `CHK(d, uhp_pkg::DIV_RST)
    finish_test();
  end
endmodule : tb_uart_host_bus_port
`default_nettype wire
